// *** hdl/cef_defines.vh ***
// offsets, field layouts, reset values and mode codes of the event flag bank
`ifndef CEF_DEFINES_VH
`define CEF_DEFINES_VH
// register offsets (byte addresses on the plain register port)
`define CEF_OFS_FLAGS     8'h00
`define CEF_OFS_INT_STAT  8'h04
`define CEF_OFS_INT_EN    8'h08
`define CEF_OFS_INT_CLR   8'h0C
// field layout
`define CEF_UNIT_LSB      0
`define CEF_UNIT_MSB      4
`define CEF_NUM_UNITS     5
`define CEF_DATA_W        8
`define CEF_INT_SRC_W     2
`define CEF_INT_HW_BIT    0
`define CEF_INT_WERR_BIT  1
// reset values
`define CEF_FLAGS_RST     8'h00
`define CEF_INT_RST       2'h0
`define CEF_RDATA_RST     8'h00
// unit operating mode codes
`define CEF_MODE_W        2
`define CEF_MODE_OFF      2'h0
`define CEF_MODE_CAPTURE  2'h1
`define CEF_MODE_COMPARE  2'h2
`define CEF_MODE_PWM      2'h3
`endif

// *** hdl/cef_unit_event.v ***
// per-unit event qualifier: passes a unit's strobe that fits its mode
`timescale 1ns/100ps
`include "cef_defines.vh"
module cef_unit_event
(
  // unit side
  input  wire [1:0] unit_operating_mode_i,
  input  wire       capture_strobe_i,
  input  wire       compare_match_i,
  input  wire       pwm_trailing_edge_i,
  // flag side
  output reg        set_req_o
);

  always @*
  begin
    case (unit_operating_mode_i)
      `CEF_MODE_CAPTURE: set_req_o = capture_strobe_i;
      `CEF_MODE_COMPARE: set_req_o = compare_match_i;
      `CEF_MODE_PWM:     set_req_o = pwm_trailing_edge_i;
      default:           set_req_o = 1'b0;
    endcase
  end

endmodule

// *** hdl/cef_irq.v ***
// sticky interrupt status with enable, write-one clear and level output
`timescale 1ns/100ps
`include "cef_defines.vh"
module cef_irq
#(
  parameter W = 2
)
(
  // clock and reset
  input  wire         mclk_i,
  input  wire         nrst_i,
  // events and control
  input  wire [W-1:0] event_i,
  input  wire         en_wr_i,
  input  wire         clr_wr_i,
  input  wire [W-1:0] wdata_i,
  // state
  output reg  [W-1:0] status_o,
  output reg  [W-1:0] enable_o,
  output wire         irq_o
);

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_o <= {W{1'b0}};
      enable_o <= {W{1'b0}};
    end
    else
    begin
      // set wins over clear so a coincident event stays visible
      status_o <= (status_o & ~({W{clr_wr_i}} & wdata_i)) | event_i;
      if (en_wr_i)
        enable_o <= wdata_i;
    end
  end

  assign irq_o = |(status_o & enable_o);

endmodule

// *** hdl/cef_flags.v ***
// capture/compare/pwm event flag register bank with register port and interrupt
`timescale 1ns/100ps
`include "cef_defines.vh"
// Summary of operation
// - Bits 0 to 4 hold one event flag per unit, unit one in bit 0 and unit five in bit 4.
// - Bits 7 to 5 are not implemented, read as zero and ignore writes.
// - A unit in capture mode sets its flag on each capture event.
// - A unit in compare mode sets its flag on each compare match.
// - A unit in pwm mode sets its flag on each trailing edge of its output.
// - Flags are sticky, hardware never clears them, software clears or writes them directly.
// - Every implemented flag is zero after any reset.
module cef_flags
#(
  parameter N = `CEF_NUM_UNITS
)
(
  // clock and reset
  input  wire          mclk_i,
  input  wire          nrst_i,
  // register port
  input  wire [7:0]    addr_i,
  input  wire [7:0]    wdata_i,
  input  wire          wr_i,
  input  wire          rd_i,
  output reg  [7:0]    rdata_o,
  // unit connections, two mode bits per unit
  input  wire [2*N-1:0] unit_operating_mode_i,
  input  wire [N-1:0]  capture_strobe_i,
  input  wire [N-1:0]  compare_match_i,
  input  wire [N-1:0]  pwm_trailing_edge_i,
  // flag state and interrupt
  output wire [N-1:0]  event_flags_o,
  output wire          irq_o
);

  //****************************************************************
  // event qualification
  //****************************************************************
  wire [N-1:0] set_req;
  reg  [N-1:0] flags;
  reg  [N-1:0] next_flags;
  wire [1:0]   int_stat;
  wire [1:0]   int_en;
  reg  [7:0]   next_rdata;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : unit
      cef_unit_event u_evt
      (
        .unit_operating_mode_i (unit_operating_mode_i[2*g+1:2*g]),
        .capture_strobe_i      (capture_strobe_i[g]),
        .compare_match_i       (compare_match_i[g]),
        .pwm_trailing_edge_i   (pwm_trailing_edge_i[g]),
        .set_req_o             (set_req[g])
      );
    end
  endgenerate

  //****************************************************************
  // flag register
  //****************************************************************
  wire flag_wr = wr_i && (addr_i == `CEF_OFS_FLAGS);

  always @*
  begin
    next_flags = flags;
    if (flag_wr)
      next_flags = wdata_i[N-1:0];
    next_flags = next_flags | set_req;
  end

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flags <= {N{1'b0}};
    else
      flags <= next_flags;
  end

  assign event_flags_o = flags;

  //****************************************************************
  // interrupt: hw set event, and a software write that dropped a set flag
  //****************************************************************
  wire hw_event  = |set_req;
  wire sw_drop   = flag_wr && |(flags & ~wdata_i[N-1:0]);

  cef_irq #(.W(`CEF_INT_SRC_W)) u_irq
  (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .event_i  ({sw_drop, hw_event}),
    .en_wr_i  (wr_i && (addr_i == `CEF_OFS_INT_EN)),
    .clr_wr_i (wr_i && (addr_i == `CEF_OFS_INT_CLR)),
    .wdata_i  (wdata_i[1:0]),
    .status_o (int_stat),
    .enable_o (int_en),
    .irq_o    (irq_o)
  );

  //****************************************************************
  // read port, data valid the cycle after the strobe
  //****************************************************************
  always @*
  begin
    next_rdata = `CEF_RDATA_RST;
    case (addr_i)
      `CEF_OFS_FLAGS:    next_rdata = {{(8-N){1'b0}}, flags};
      `CEF_OFS_INT_STAT: next_rdata = {6'h00, int_stat};
      `CEF_OFS_INT_EN:   next_rdata = {6'h00, int_en};
      default:           next_rdata = `CEF_RDATA_RST;
    endcase
  end

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= `CEF_RDATA_RST;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= `CEF_RDATA_RST;
  end

endmodule

// *** verification/cef_flags_checker.sv ***
// assertion checker for the event flag bank
`timescale 1ns/100ps
module cef_flags_checker
#(
  parameter N = 5
)
(
  input logic           mclk_i, nrst_i, wr_i, rd_i, irq_o,
  input logic [7:0]     addr_i, wdata_i, rdata_o,
  input logic [2*N-1:0] unit_operating_mode_i,
  input logic [N-1:0]   capture_strobe_i, compare_match_i, pwm_trailing_edge_i, event_flags_o
);
  wire       fw = wr_i && addr_i == 8'h00;
  wire       qt = !capture_strobe_i && !compare_match_i && !pwm_trailing_edge_i;
  wire [1:0] m0 = unit_operating_mode_i[1:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_cap; capture_strobe_i[0] && m0 == 2'h1 |=> event_flags_o[0]; endproperty
  a_cap: assert property (p_cap) else $error("capture lost");
  property p_cmp; compare_match_i[0] && m0 == 2'h2 |=> event_flags_o[0]; endproperty
  a_cmp: assert property (p_cmp) else $error("match lost");
  property p_pwm; pwm_trailing_edge_i[0] && m0 == 2'h3 |=> event_flags_o[0]; endproperty
  a_pwm: assert property (p_pwm) else $error("edge lost");
  property p_hold; !fw && qt |=> $stable(event_flags_o); endproperty
  a_hold: assert property (p_hold) else $error("flag moved");
  property p_wr; fw && qt |=> event_flags_o == $past(wdata_i[N-1:0]); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_rd; rd_i && addr_i == 8'h00 |=> rdata_o[N-1:0] == $past(event_flags_o); endproperty
  a_rd: assert property (p_rd) else $error("read wrong");
  property p_hi; rd_i |=> rdata_o[7:N] == 0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_rst; disable iff (1'b0) !nrst_i |-> event_flags_o == 0 && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  c_col: cover property (fw && capture_strobe_i[0] && m0 == 2'h1);
  c_rd: cover property (rd_i && addr_i == 8'h00);
  c_irq: cover property (irq_o);
endmodule
bind cef_flags cef_flags_checker #(.N(N)) chk
(
  .mclk_i                (mclk_i),
  .nrst_i                (nrst_i),
  .wr_i                  (wr_i),
  .rd_i                  (rd_i),
  .irq_o                 (irq_o),
  .addr_i                (addr_i),
  .wdata_i               (wdata_i),
  .rdata_o               (rdata_o),
  .unit_operating_mode_i (unit_operating_mode_i),
  .capture_strobe_i      (capture_strobe_i),
  .compare_match_i       (compare_match_i),
  .pwm_trailing_edge_i   (pwm_trailing_edge_i),
  .event_flags_o         (event_flags_o)
);

// *** verification/cef_flags_tb_top.sv ***
// self-checking bench for the event flag bank
`timescale 1ns/100ps
module cef_flags_tb_top;
  // reset starts high and falls at time zero, so the asynchronous branch sees a real edge
  logic        mclk = 1'b0, nrst = 1'b1, wr = 1'b0, rd = 1'b0, irq, pw, pr;
  logic [7:0]  ad = 8'h00, wd = 8'h00, rdat, pa, pd;
  logic [9:0]  md = 10'h000;
  logic [4:0]  cs = 5'h00, cm = 5'h00, pt = 5'h00, fl, f, ph;
  logic [31:0] r = 32'h414A3107, q;
  int          mismatches = 0, checks_done = 0;
  cef_flags uut (.mclk_i(mclk), .nrst_i(nrst), .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdat), .unit_operating_mode_i(md), .capture_strobe_i(cs), .compare_match_i(cm),
    .pwm_trailing_edge_i(pt), .event_flags_o(fl), .irq_o(irq));
  initial forever #5 mclk = !mclk;
  function logic [4:0] hs(input logic [9:0] m, input logic [4:0] a, b, c);
    for (int k = 0; k < 5; k++)
      hs[k] = a[k] && m[2*k+:2] == 2'h1 || b[k] && m[2*k+:2] == 2'h2 || c[k] && m[2*k+:2] == 2'h3;
  endfunction
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s;
    repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  endfunction
  task ck(input logic [7:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task w(input logic [7:0] a, d);
    @(posedge mclk);
    {ad, wd, wr} <= {a, d, 1'b1};
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #300000;
    mismatches++;
    conclude;
  end
  initial
  begin
    {pw, pr, pa, pd, f, ph} = '0;
    nrst <= 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2000)
    begin
      @(posedge mclk);
      q = r;
      r = lfsr(r);
      {wr, rd, ad, wd, md} <= {q[0], !q[0] && q[1], q[2] ? 8'h00 : {3'h0, q[7:3]}, q[25:8]};
      {cs, cm, pt} <= r[14:0] & r[29:15];
      #1;
      if (pr && (pa == 8'h00 || pa[1:0] != 2'h0))
        ck(rdat, pa == 8'h00 ? {3'h0, f} : 8'h00);
      f = ph | (pw && pa == 8'h00 ? pd[4:0] : f);
      ck({3'h0, fl}, {3'h0, f});
      ph = hs(md, cs, cm, pt);
      {pw, pr, pa, pd} = {wr, rd, ad, wd};
    end
    $display("random test done");
    @(posedge mclk);
    {wr, rd, cs, cm, pt} <= '0;
    w(8'h08, 8'h01);
    w(8'h0C, 8'hFF);
    @(posedge mclk);
    {md, cs} <= {10'h001, 5'h01};
    @(posedge mclk);
    cs <= 5'h00;
    #1;
    ck({7'h0, irq}, 8'h01);
    w(8'h08, 8'h00);
    ck({7'h0, irq}, 8'h00);
    w(8'h0C, 8'h01);
    w(8'h08, 8'h01);
    ck({7'h0, irq}, 8'h00);
    $display("interrupt test done");
    @(posedge mclk);
    cs <= 5'h01;
    @(posedge mclk);
    cs <= 5'h00;
    #1;
    ck({7'h0, irq}, 8'h01);
    ck({7'h0, fl[0]}, 8'h01);
    // reset in mid-run with a flag and the interrupt up
    @(posedge mclk);
    nrst <= 1'b0;
    #1;
    ck({7'h0, irq}, 8'h00);
    ck({3'h0, fl}, 8'h00);
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    ck({3'h0, fl}, 8'h00);
    ck(rdat, 8'h00);
    ck({7'h0, irq}, 8'h00);
    $display("reset test done");
    conclude;
  end
endmodule
